// ### core/i2cm_pkg.sv
package i2cm_pkg;

    // Bit positions in the status/control word
    localparam int STAT_RX_FULL_BIT = 7;
    localparam int STAT_TX_EMPTY_BIT = 3;
    localparam int STAT_STOP_RD_BIT = 1;
    localparam int STAT_STOP_WR_BIT = 0;

    // Direction bit inside the target address byte, 1 = read
    localparam int ADDR_DIR_BIT = 0;

    // Reset values of the flags and registers
    localparam logic TX_EMPTY_RESET = 1'b1;
    localparam logic RX_FULL_RESET = 1'b0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Command queue depth and link clock cycles per quarter of a serial bit
    localparam int CMD_FIFO_DEPTH = 4;
    localparam int QUARTER_CYCLES = 2;

    // Index of the last data bit and of the acknowledge slot
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // One queued byte with the context it is sent under
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] addr;
        logic stop_wr;
    } i2cm_cmd_s;

    // Link-side sequencer states
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_START = 3'b001,
        L_TX = 3'b010,
        L_RX = 3'b011,
        L_STOP = 3'b100
    } i2cm_link_state_e;

endpackage : i2cm_pkg

// ### core/i2cm_ctrl.sv
`timescale 1ns/1ns

module i2cm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    wire [AW-1:0] next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;

    assign out_data = mem[rd_ptr];

    // Full and empty are registered so both handshakes see clean flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= (next_count != FULL_COUNT);
            out_valid <= (next_count != '0);
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
        end
    end

    // Storage needs no reset; out_valid guards it
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : i2cm_fifo

module i2cm_ctrl #(
    parameter int QUARTER = i2cm_pkg::QUARTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic tx_wr,
    input wire logic [7:0] tx_wdata,
    input wire logic addr_wr,
    input wire logic [7:0] addr_wdata,
    input wire logic rx_rd,
    input wire logic stop_after_write,
    input wire logic stop_after_read,
    output logic tx_ready,
    output logic tx_empty_flag,
    output logic rx_full_flag,
    output logic [7:0] rx_data_reg,
    output logic [7:0] serial_status_ctrl,
    output logic tx_empty_irq,
    output logic rx_full_irq,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe
);
    import i2cm_pkg::*;

    localparam int CMD_W = $bits(i2cm_cmd_s);
    localparam logic [7:0] QUARTER_LAST = 8'(QUARTER - 1);

    // Processor-side state
    logic [7:0] target_addr_reg;
    logic [2:0] outstanding;
    logic req_tg;
    i2cm_cmd_s hold_cmd;
    logic ack_s1, ack_s2;
    logic txd_s1, txd_s2, txd_s3;
    logic rxd_s1, rxd_s2, rxd_s3;

    // Link-side state
    logic lrst_s1, lrst;
    logic req_s1, req_s2, req_seen;
    logic srd_s1, srd_s2;
    logic sda_s1, sda_s2;
    logic [7:0] div;
    i2cm_link_state_e st;
    logic [1:0] q;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    i2cm_cmd_s cmd;
    logic open_txn;
    logic in_addr;
    logic rd_last;
    logic [7:0] rx_byte;
    logic tx_tg, rx_tg;

    // Queue between processor writes and the link handshake
    i2cm_cmd_s fifo_in;
    i2cm_cmd_s fifo_out;
    logic fifo_valid;
    wire hs_busy = (req_tg != ack_s2);
    wire fifo_pop = fifo_valid && !hs_busy;

    // Commands carry the write-stop choice made at write time
    assign fifo_in = '{data: tx_wdata, addr: target_addr_reg, stop_wr: stop_after_write};

    i2cm_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(CMD_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(tx_wr),
        .in_ready(tx_ready),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(!hs_busy),
        .out_data(fifo_out)
    );

    // Processor-side decode; a write refused by a full queue has no effect
    wire wr_ok = tx_wr && tx_ready;
    wire wr_is_read = wr_ok && target_addr_reg[ADDR_DIR_BIT];
    wire tx_evt = txd_s2 ^ txd_s3;
    wire rx_evt = rxd_s2 ^ rxd_s3;
    wire [2:0] next_outstanding = outstanding + 3'(wr_ok) - 3'(tx_evt);
    wire tx_set = tx_evt && (next_outstanding == 3'h0);
    wire next_tx_empty = tx_set ? 1'b1 : (wr_ok ? 1'b0 : tx_empty_flag);
    wire next_rx_full = rx_evt ? 1'b1 : ((rx_rd || wr_is_read) ? 1'b0 : rx_full_flag);

    // Synchronisers for link events and the handshake acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {ack_s1, ack_s2} <= 2'b00;
            {txd_s1, txd_s2, txd_s3} <= 3'b000;
            {rxd_s1, rxd_s2, rxd_s3} <= 3'b000;
        end else begin
            {ack_s1, ack_s2} <= {req_seen, ack_s1};
            {txd_s1, txd_s2, txd_s3} <= {tx_tg, txd_s1, txd_s2};
            {rxd_s1, rxd_s2, rxd_s3} <= {rx_tg, rxd_s1, rxd_s2};
        end
    end

    // Handshake launch: the held word is stable long before the toggle is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_tg <= 1'b0;
            hold_cmd <= '0;
        end else if (fifo_pop) begin
            req_tg <= ~req_tg;
            hold_cmd <= fifo_out;
        end
    end

    // Processor-visible registers; hardware set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_addr_reg <= BYTE_RESET;
            outstanding <= 3'h0;
            tx_empty_flag <= TX_EMPTY_RESET;
            rx_full_flag <= RX_FULL_RESET;
            rx_data_reg <= BYTE_RESET;
            serial_status_ctrl <= BYTE_RESET;
            tx_empty_irq <= 1'b0;
            rx_full_irq <= 1'b0;
        end else begin
            if (addr_wr) begin
                target_addr_reg <= addr_wdata;
            end
            outstanding <= next_outstanding;
            tx_empty_flag <= next_tx_empty;
            rx_full_flag <= next_rx_full;
            if (rx_evt) begin
                rx_data_reg <= rx_byte;
            end
            serial_status_ctrl <= BYTE_RESET;
            serial_status_ctrl[STAT_RX_FULL_BIT] <= next_rx_full;
            serial_status_ctrl[STAT_TX_EMPTY_BIT] <= next_tx_empty;
            serial_status_ctrl[STAT_STOP_RD_BIT] <= stop_after_read;
            serial_status_ctrl[STAT_STOP_WR_BIT] <= stop_after_write;
            tx_empty_irq <= tx_set;
            rx_full_irq <= rx_evt;
        end
    end

    // Link reset: asserted at once, released on the link clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            {lrst_s1, lrst} <= 2'b11;
        end else begin
            {lrst_s1, lrst} <= {1'b0, lrst_s1};
        end
    end

    // Link-side synchronisers for request toggle, read-stop level and data pin
    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            {req_s1, req_s2} <= 2'b00;
            {srd_s1, srd_s2} <= 2'b00;
            {sda_s1, sda_s2} <= 2'b11;
        end else begin
            {req_s1, req_s2} <= {req_tg, req_s1};
            {srd_s1, srd_s2} <= {stop_after_read, srd_s1};
            {sda_s1, sda_s2} <= {sda_in, sda_s1};
        end
    end

    // Quarter-bit tick every QUARTER link clocks; one serial clock period is four ticks
    wire tick = (div == QUARTER_LAST);
    wire new_cmd = (req_s2 != req_seen);
    wire byte_done = (bit_cnt == ACK_SLOT);
    wire addr_is_read = cmd.addr[ADDR_DIR_BIT];

    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            div <= 8'h00;
        end else begin
            div <= tick ? 8'h00 : div + 8'h01;
        end
    end

    // Pins are open drain: only the enables move, the data level stays low
    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
        end
    end

    // Bit sequencer; slave acknowledge is not checked, software owns recovery
    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            st <= L_IDLE;
            q <= 2'h0;
            bit_cnt <= 4'h0;
            sh <= BYTE_RESET;
            cmd <= '0;
            req_seen <= 1'b0;
            open_txn <= 1'b0;
            in_addr <= 1'b0;
            rd_last <= 1'b0;
            rx_byte <= BYTE_RESET;
            tx_tg <= 1'b0;
            rx_tg <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else if (tick) begin
            q <= q + 2'h1;
            unique case (st)
                L_IDLE: begin
                    q <= 2'h0;
                    if (new_cmd) begin
                        cmd <= hold_cmd;
                        req_seen <= req_s2;
                        if (!open_txn || hold_cmd.addr[ADDR_DIR_BIT]) begin
                            st <= L_START;
                        end else begin
                            st <= L_TX;
                            sh <= hold_cmd.data;
                            in_addr <= 1'b0;
                            bit_cnt <= 4'h0;
                        end
                    end
                end
                L_START: begin
                    unique case (q)
                        2'h0: sda_oe <= 1'b0;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b1;
                        2'h3: begin
                            scl_oe <= 1'b1;
                            st <= L_TX;
                            sh <= cmd.addr;
                            in_addr <= 1'b1;
                            bit_cnt <= 4'h0;
                        end
                    endcase
                end
                L_TX: begin
                    unique case (q)
                        2'h0: sda_oe <= byte_done ? 1'b0 : ~sh[7];
                        2'h1: scl_oe <= 1'b0;
                        2'h2: ;
                        2'h3: begin
                            scl_oe <= 1'b1;
                            if (!byte_done) begin
                                sh <= {sh[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end else if (in_addr && addr_is_read) begin
                                tx_tg <= ~tx_tg;
                                open_txn <= 1'b1;
                                st <= L_RX;
                                bit_cnt <= 4'h0;
                            end else if (in_addr) begin
                                sh <= cmd.data;
                                in_addr <= 1'b0;
                                bit_cnt <= 4'h0;
                            end else begin
                                tx_tg <= ~tx_tg;
                                open_txn <= !cmd.stop_wr;
                                st <= cmd.stop_wr ? L_STOP : L_IDLE;
                            end
                        end
                    endcase
                end
                L_RX: begin
                    unique case (q)
                        2'h0: begin
                            sda_oe <= byte_done ? ~srd_s2 : 1'b0;
                            if (byte_done) begin
                                rd_last <= srd_s2;
                            end
                        end
                        2'h1: scl_oe <= 1'b0;
                        2'h2: begin
                            if (!byte_done) begin
                                sh <= {sh[6:0], sda_s2};
                            end
                        end
                        2'h3: begin
                            scl_oe <= 1'b1;
                            if (bit_cnt == LAST_DATA_BIT) begin
                                rx_byte <= sh;
                                rx_tg <= ~rx_tg;
                            end
                            if (!byte_done) begin
                                bit_cnt <= bit_cnt + 4'h1;
                            end else if (rd_last) begin
                                st <= L_STOP;
                            end else begin
                                bit_cnt <= 4'h0;
                            end
                        end
                    endcase
                end
                L_STOP: begin
                    unique case (q)
                        2'h0: sda_oe <= 1'b1;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b0;
                        2'h3: begin
                            st <= L_IDLE;
                            open_txn <= 1'b0;
                        end
                    endcase
                end
                default: st <= L_IDLE;
            endcase
        end
    end
endmodule : i2cm_ctrl

// ### tb/i2cm_ctrl_props.sv
`timescale 1ns/1ns

// Port-level checks for the serial controller; sees only the controller's pins
module i2cm_ctrl_props #(
    parameter int QUARTER = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic tx_wr,
    input wire logic [7:0] tx_wdata,
    input wire logic addr_wr,
    input wire logic [7:0] addr_wdata,
    input wire logic rx_rd,
    input wire logic stop_after_write,
    input wire logic stop_after_read,
    input wire logic tx_ready,
    input wire logic tx_empty_flag,
    input wire logic rx_full_flag,
    input wire logic [7:0] rx_data_reg,
    input wire logic [7:0] serial_status_ctrl,
    input wire logic tx_empty_irq,
    input wire logic rx_full_irq,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe
);
    import i2cm_pkg::*;
    logic [7:0] tgt;

    // Shadow of the target address, so read-starting writes can be told apart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tgt <= 8'h00;
        else if (addr_wr) tgt <= addr_wdata;
    end

    property p_tx_clear;
        @(posedge clk) disable iff (rst) tx_wr && tx_ready |=> !tx_empty_flag;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("write left tx empty set");

    property p_tx_irq_rise;
        @(posedge clk) disable iff (rst) $rose(tx_empty_flag) |-> tx_empty_irq ##1 !tx_empty_irq;
    endproperty
    a_tx_irq_rise: assert property (p_tx_irq_rise) else $error("tx empty irq wrong");

    property p_rx_irq;
        @(posedge clk) disable iff (rst) rx_full_irq |-> rx_full_flag ##1 !rx_full_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq without full flag");

    property p_rx_rise;
        @(posedge clk) disable iff (rst) $rose(rx_full_flag) |-> rx_full_irq;
    endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("rx full set silently");

    property p_rx_clear;
        @(posedge clk) disable iff (rst) rx_rd |=> !rx_full_flag || rx_full_irq;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("read kept rx full");

    property p_read_clr;
        @(posedge clk) disable iff (rst)
            tx_wr && tx_ready && tgt[ADDR_DIR_BIT] |=> !rx_full_flag || rx_full_irq;
    endproperty
    a_read_clr: assert property (p_read_clr) else $error("read start kept rx full");

    property p_status_map;
        @(posedge clk) disable iff (rst) !$past(rst) |-> serial_status_ctrl ==
            {rx_full_flag, 3'h0, tx_empty_flag, 1'b0, $past(stop_after_read),
             $past(stop_after_write)};
    endproperty
    a_status_map: assert property (p_status_map) else $error("status word mismatch");

    property p_open_drain;
        @(posedge link_clk) disable iff (rst) sda_out == 1'b0 && scl_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    // A clock phase is two link clocks at least, which is two quarters only when the quarter is one clock
    property p_scl_phase;
        @(posedge link_clk) disable iff (rst) $changed(scl_oe) |=> $stable(scl_oe);
    endproperty
    a_scl_phase: assert property (p_scl_phase) else $error("clock phase too short");
endmodule : i2cm_ctrl_props

bind i2cm_ctrl i2cm_ctrl_props #(.QUARTER(QUARTER)) u_props (
    .clk(clk), .rst(rst), .link_clk(link_clk), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
    .addr_wr(addr_wr), .addr_wdata(addr_wdata), .rx_rd(rx_rd),
    .stop_after_write(stop_after_write), .stop_after_read(stop_after_read),
    .tx_ready(tx_ready), .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
    .rx_data_reg(rx_data_reg), .serial_status_ctrl(serial_status_ctrl),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe)
);

// ### tb/i2cm_eeprom_model.sv
`timescale 1ns/1ns

// Serial memory stand-in: acks written bytes, serves 8'h5a upward on reads
module i2cm_eeprom_model (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rd_byte = 8'h00;
    logic rd_mode = 1'b0;
    logic addr_ph = 1'b0;
    logic nacked = 1'b0;
    int nbit = -2;
    int n_start = 0;
    int n_stop = 0;
    int n_rd = 0;
    logic [7:0] got[$];

    initial sda_pull = 1'b0;

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            n_start++;
            nbit = -1;
            addr_ph = 1'b1;
            rd_mode = 1'b0;
            nacked = 1'b0;
        end
    end

    // Stop parks the model until the next start
    always @(posedge sda) begin
        if (scl === 1'b1 && nbit > -2) begin
            n_stop++;
            nbit = -2;
        end
    end

    // Bits are taken while the clock is high
    always @(posedge scl) begin
        if (nbit >= 0 && nbit < 8) sh = {sh[6:0], sda};
        if (nbit == 8 && rd_mode && sda === 1'b1) nacked = 1'b1;
    end

    // The data line only moves while the clock is low, so no false start or stop
    always @(negedge scl) begin
        if (nbit > -2) begin
            nbit++;
            if (nbit == 8 && !rd_mode) begin
                got.push_back(sh);
                if (addr_ph) rd_mode = sh[0];
                addr_ph = 1'b0;
                sda_pull = 1'b1;
            end else if (nbit == 9) begin
                nbit = 0;
                sda_pull = 1'b0;
                if (rd_mode && !nacked) begin
                    rd_byte = 8'h5a + n_rd[7:0];
                    n_rd++;
                    sda_pull = ~rd_byte[7];
                end
            end else if (rd_mode && !nacked && nbit < 8) begin
                sda_pull = ~rd_byte[7 - nbit];
            end else begin
                sda_pull = 1'b0;
            end
        end
    end
endmodule : i2cm_eeprom_model

// ### tb/i2cm_ctrl_bench.sv
`timescale 1ns/1ns

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module i2cm_ctrl_bench;
    import i2cm_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic tx_wr = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic addr_wr = 1'b0;
    logic [7:0] addr_wdata = 8'h00;
    logic rx_rd = 1'b0;
    logic stop_after_write = 1'b0;
    logic stop_after_read = 1'b0;
    logic tx_ready, tx_empty_flag, rx_full_flag, tx_empty_irq, rx_full_irq;
    logic [7:0] rx_data_reg, serial_status_ctrl;
    logic sda_out, sda_oe, scl_out, scl_oe, m_pull;
    logic [7:0] exp_q[$];
    logic [7:0] exp_rd = 8'h5a;
    int n_fail = 0;
    int total_checks = 0;
    int base, s_start, s_stop;
    // Both lines are pulled up; any party with its enable high pulls low
    wire sda_w = ~(sda_oe | m_pull);
    wire scl_w = ~scl_oe;

    // 8 ns processor clock; 64 ns link clock offset so the phases never align
    always #4 clk = ~clk;
    initial begin #3; forever #32 link_clk = ~link_clk; end

    i2cm_ctrl #(.QUARTER(1)) i_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .tx_wr(tx_wr),
        .tx_wdata(tx_wdata), .addr_wr(addr_wr), .addr_wdata(addr_wdata), .rx_rd(rx_rd),
        .stop_after_write(stop_after_write), .stop_after_read(stop_after_read),
        .tx_ready(tx_ready), .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
        .rx_data_reg(rx_data_reg), .serial_status_ctrl(serial_status_ctrl),
        .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
    i2cm_eeprom_model i_eep (.scl(scl_w), .sda(sda_w), .sda_pull(m_pull));

    task automatic print_verdict;
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic set_addr(input logic [7:0] a);
        @(negedge clk);
        addr_wr = 1'b1;
        addr_wdata = a;
        @(negedge clk);
        addr_wr = 1'b0;
    endtask : set_addr

    task automatic send(input logic [7:0] b, input logic stop);
        @(negedge clk);
        tx_wr = 1'b1;
        tx_wdata = b;
        stop_after_write = stop;
        @(negedge clk);
        tx_wr = 1'b0;
        `CHK(serial_status_ctrl[STAT_TX_EMPTY_BIT], 1'b0);
        `CHK(serial_status_ctrl[STAT_STOP_WR_BIT], stop);
    endtask : send

    // Waiting for the flag before the next write keeps the documented flow
    task automatic wait_tx;
        for (int i = 0; i < 4000 && tx_empty_irq !== 1'b1; i++) @(negedge clk);
        `CHK(tx_empty_irq, 1'b1);
        `CHK(serial_status_ctrl[STAT_TX_EMPTY_BIT], 1'b1);
        @(negedge clk);
    endtask : wait_tx

    task automatic get_rx(input logic rd);
        for (int i = 0; i < 1000 && rx_full_irq !== 1'b1; i++) @(negedge clk);
        `CHK(serial_status_ctrl[STAT_RX_FULL_BIT], 1'b1);
        `CHK(rx_data_reg, exp_rd);
        exp_rd++;
        if (rd) begin
            rx_rd = 1'b1;
            @(negedge clk);
            rx_rd = 1'b0;
            `CHK(rx_full_flag, 1'b0);
        end
    endtask : get_rx

    task automatic mark;
        base = i_eep.got.size();
        s_start = i_eep.n_start;
        s_stop = i_eep.n_stop;
        exp_q = {};
    endtask : mark

    task automatic wait_stop;
        for (int i = 0; i < 400 && i_eep.n_stop == s_stop; i++) @(negedge clk);
    endtask : wait_stop

    task automatic chk_log;
        foreach (exp_q[k]) `CHK(i_eep.got[base + k], exp_q[k]);
        `CHK(i_eep.got.size(), base + exp_q.size());
    endtask : chk_log

    task automatic t_reset;
        `CHK({tx_empty_flag, rx_full_flag, tx_ready}, {TX_EMPTY_RESET, RX_FULL_RESET, 1'b1});
        `CHK({rx_data_reg, serial_status_ctrl}, {BYTE_RESET, 8'h08});
        `CHK({sda_w, scl_w}, 2'b11);
    endtask : t_reset

    task automatic t_byte_write;
        mark();
        exp_q = {8'ha0, 8'h01, 8'h23, 8'hcd};
        set_addr(8'ha0);
        send(8'h01, 1'b0);
        wait_tx();
        send(8'h23, 1'b0);
        wait_tx();
        `CHK(i_eep.n_stop, s_stop);
        send(8'hcd, 1'b1);
        wait_tx();
        wait_stop();
        `CHK(i_eep.n_start - s_start, 1);
        `CHK(i_eep.n_stop - s_stop, 1);
        chk_log();
    endtask : t_byte_write

    // Last byte is left unread so the next read start must clear the flag
    task automatic t_seq_read;
        mark();
        exp_q = {8'ha1};
        stop_after_read = 1'b0;
        set_addr(8'ha1);
        send(8'hff, 1'b0);
        wait_tx();
        for (int k = 0; k < 31; k++) get_rx(1'b1);
        for (int i = 0; i < 400 && i_eep.nbit != 0; i++) @(negedge clk);
        `CHK(i_eep.n_stop, s_stop);
        stop_after_read = 1'b1;
        get_rx(1'b0);
        wait_stop();
        `CHK(i_eep.n_stop - s_stop, 1);
        `CHK(i_eep.n_rd, 32);
        chk_log();
    endtask : t_seq_read

    task automatic t_rand_read;
        mark();
        exp_q = {8'ha0, 8'h00, 8'h10, 8'ha1};
        set_addr(8'ha0);
        send(8'h00, 1'b0);
        wait_tx();
        send(8'h10, 1'b0);
        wait_tx();
        set_addr(8'ha1);
        `CHK(rx_full_flag, 1'b1);
        send(8'hff, 1'b0);
        `CHK(rx_full_flag, 1'b0);
        wait_tx();
        get_rx(1'b1);
        wait_stop();
        `CHK(i_eep.n_start - s_start, 2);
        `CHK(i_eep.n_stop - s_stop, 1);
        chk_log();
    endtask : t_rand_read

    // Burst past the queue depth; refused bytes must never reach the line
    task automatic t_burst;
        mark();
        exp_q = {8'ha0};
        set_addr(8'ha0);
        stop_after_write = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (tx_ready === 1'b1) exp_q.push_back(8'h40 + i[7:0]);
            tx_wr = 1'b1;
            tx_wdata = 8'h40 + i[7:0];
        end
        @(negedge clk);
        tx_wr = 1'b0;
        `CHK(exp_q.size() < 9, 1'b1);
        wait_tx();
        send(8'h7e, 1'b1);
        exp_q.push_back(8'h7e);
        wait_tx();
        wait_stop();
        `CHK(i_eep.n_stop - s_stop, 1);
        chk_log();
    endtask : t_burst

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_byte_write();
        t_seq_read();
        t_rand_read();
        t_burst();
        print_verdict();
    end

    // Watchdog at 50k cycles, well past the roughly 15k cycles the sequence needs
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end
endmodule : i2cm_ctrl_bench
